// [test/emcs_phy_model.sv]
// emcs_phy_model: receive side of the physical layer transceiver
`timescale 1ns/1ps
module emcs_phy_model (
    // link clock, free running
    input  wire logic i_clk_link,
    // receive lines
    output logic      o_valid,
    output logic      o_err,
    output logic      o_sfd,
    output logic      o_pre_bad,
    output logic      o_end,
    output logic [4:0] o_st
);
    initial {o_valid, o_err, o_sfd, o_pre_bad, o_end, o_st} = '0;
    // f: pre_bad fcs mcast pause filt copied err_valid err_idle
    task automatic send(input logic [7:0] f);
        @(posedge i_clk_link);
        o_valid <= 1'b1;
        o_sfd <= 1'b1;
        o_err <= f[1];
        o_pre_bad <= f[7];
        repeat (4) @(posedge i_clk_link);
        o_valid <= 1'b0;
        o_err <= f[0];
        @(posedge i_clk_link);
        o_end <= 1'b1;
        o_st <= f[6:2];
        @(posedge i_clk_link);
        // status lines flip while end, err and sfd clear so stale values never pass
        o_end <= 1'b0;
        o_err <= 1'b0;
        o_sfd <= 1'b0;
        o_st <= ~f[6:2];
        repeat (8) @(posedge i_clk_link);
    endtask
endmodule // emcs_phy_model

// [test/emcs_top_monitor.sv]
// emcs_top_monitor: assertions on register reads, status and gap outputs
`timescale 1ns/1ps
module emcs_top_monitor #(parameter int STRETCH_DIV = 4) (
    // system and register bus
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    // transmit and status
    input wire logic        i_tx_done,
    input wire logic [15:0] i_tx_len,
    input wire logic        i_tx_pause_auto,
    input wire logic        i_tx_ok,
    input wire logic        o_rx_frame_keep,
    input wire logic        o_rx_fcs_status,
    input wire logic        o_rx_status_valid,
    input wire logic [15:0] o_ipg_nibbles
);
    logic [31:0] cfg_reg;
    logic [15:0] want_reg;
    logic [15:0] div;
    logic        rd;
    assign div = 16'(i_tx_len / STRETCH_DIV);
    assign rd = i_psel && i_penable && !i_pwrite;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // ----
    // shadow of config and expected gap
    // ----
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cfg_reg <= 32'h0008_0000;
        end else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h004) begin
            cfg_reg <= i_pwdata;
        end
        if (i_tx_done) begin
            want_reg <= (div > 16'h0018) ? div : 16'h0018;
        end
    end
    chk_high_upper:
        assert property (rd && i_paddr == 12'h104 |-> o_prdata[31:16] == 16'h0000)
        else $error("octet high upper half not zero");
    chk_cfg_readback:
        assert property (rd && i_paddr == 12'h004 |-> o_prdata == (cfg_reg & 32'hFEFF_FFFF))
        else $error("config readback wrong");
    chk_fcs_reject:
        assert property (o_rx_status_valid && o_rx_fcs_status && !cfg_reg[26]
            |-> !o_rx_frame_keep) else $error("checksum error frame kept");
    chk_fcs_stable:
        assert property (!o_rx_status_valid |-> $stable(o_rx_fcs_status))
        else $error("checksum status moved without pulse");
    chk_keep_stable:
        assert property (!o_rx_status_valid |-> $stable(o_rx_frame_keep))
        else $error("keep moved without pulse");
    chk_status_pulse:
        assert property (o_rx_status_valid |=> !o_rx_status_valid)
        else $error("status pulse too long");
    chk_gap_floor:
        assert property (o_ipg_nibbles >= 16'h0018) else $error("gap below floor");
    chk_gap_value:
        assert property (i_tx_done && i_tx_ok && !i_tx_pause_auto |-> ##2
            o_ipg_nibbles == (cfg_reg[28] ? want_reg : 16'h0018))
        else $error("gap value wrong");
    cover property (o_rx_status_valid && o_rx_frame_keep && o_rx_fcs_status);
    cover property (i_tx_done && i_tx_pause_auto);
    cover property (o_ipg_nibbles > 16'h0018);
endmodule // emcs_top_monitor
bind emcs_top emcs_top_monitor #(.STRETCH_DIV(STRETCH_DIV)) mon_u (.*);

// [test/testbench.sv]
// testbench: register, receive acceptance and statistics checks
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] f;
        logic       busy;
        logic       keep;
        logic       mc;
    } emcs_row_t;
    logic i_clk_sys = 0, i_clk_link = 0, i_rst = 1, i_psel = 0, i_penable = 0;
    logic i_pwrite = 0, i_tx_busy = 0, i_tx_done = 0, i_tx_pause_auto = 0;
    logic i_tx_ok = 0, o_pready, o_pslverr, o_rx_frame_keep, o_rx_fcs_status;
    logic i_rx_valid_input, i_rx_error_input, i_rx_sfd_ok, i_rx_preamble_bad;
    logic i_rx_fcs_bad, i_rx_multicast, i_rx_pause, i_rx_filter_pass;
    logic i_rx_mem_copied, i_rx_end, o_rx_status_valid;
    logic [11:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata, q;
    logic [15:0] i_tx_len = '0, o_ipg_nibbles;
    int errors = 0, checks = 0, mc = 0, n;
    emcs_row_t rows [13] = '{'{8'h00, 8'h2C, 1'b0, 1'b1, 1'b1},
        '{8'h00, 8'h6C, 1'b0, 1'b0, 1'b0}, '{8'h04, 8'h6C, 1'b0, 1'b1, 1'b0},
        '{8'h00, 8'hAC, 1'b0, 1'b0, 1'b0}, '{8'h20, 8'hAC, 1'b0, 1'b1, 1'b1},
        '{8'h00, 8'h2D, 1'b0, 1'b0, 1'b0}, '{8'h40, 8'h2D, 1'b0, 1'b1, 1'b1},
        '{8'h40, 8'h2E, 1'b0, 1'b0, 1'b0}, '{8'h00, 8'h3C, 1'b0, 1'b1, 1'b0},
        '{8'h00, 8'h24, 1'b0, 1'b1, 1'b0}, '{8'h00, 8'h28, 1'b0, 1'b1, 1'b0},
        '{8'h00, 8'h2C, 1'b1, 1'b0, 1'b0}, '{8'h02, 8'h2C, 1'b1, 1'b1, 1'b1}};
    emcs_top dut_u (.*);
    emcs_phy_model phy_u (.i_clk_link(i_clk_link), .o_valid(i_rx_valid_input),
        .o_err(i_rx_error_input), .o_sfd(i_rx_sfd_ok), .o_end(i_rx_end),
        .o_pre_bad(i_rx_preamble_bad), .o_st({i_rx_fcs_bad, i_rx_multicast,
        i_rx_pause, i_rx_filter_pass, i_rx_mem_copied}));
    initial forever #20 i_clk_sys = ~i_clk_sys;
    initial begin
        #7;
        forever #24 i_clk_link = ~i_clk_link;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        q = o_prdata;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic tx(input logic [15:0] len, input logic p, input logic ok);
        @(posedge i_clk_sys);
        {i_tx_done, i_tx_len, i_tx_pause_auto, i_tx_ok} <= {1'b1, len, p, ok};
        @(posedge i_clk_sys);
        i_tx_done <= 1'b0;
        repeat (3) @(negedge i_clk_sys);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        apb(1'b0, 12'h004, '0);
        chk(q, 32'h0008_0000);
        chk(32'(o_pslverr), 32'h0000_0000);
        foreach (rows[i]) begin
            apb(1'b1, 12'h004, {rows[i].cfg, 24'h0});
            i_tx_busy <= rows[i].busy;
            // config and busy need two link edges to reach the receiver
            repeat (3) @(posedge i_clk_link);
            fork
                phy_u.send(rows[i].f);
                begin
                    n = 0;
                    do @(negedge i_clk_sys);
                    while (o_rx_status_valid !== 1'b1 && ++n < 500);
                    chk(32'(o_rx_frame_keep), 32'(rows[i].keep));
                    chk(32'(o_rx_fcs_status), 32'(rows[i].f[6]));
                end
            join
            mc += int'(rows[i].mc);
            apb(1'b0, 12'h160, '0);
            chk(q, 32'(mc));
        end
        i_tx_busy <= 1'b0;
        apb(1'b0, 12'h190, '0);
        chk(q, 32'h0000_0002);
        apb(1'b1, 12'h004, '0);
        tx(16'h03E8, 1'b0, 1'b1);
        chk(32'(o_ipg_nibbles), 32'h0000_0018);
        apb(1'b1, 12'h004, 32'h1000_0000);
        tx(16'h03E8, 1'b0, 1'b1);
        chk(32'(o_ipg_nibbles), 32'h0000_00FA);
        tx(16'h003C, 1'b1, 1'b1);
        tx(16'h00C8, 1'b0, 1'b0);
        tx(16'hFFFF, 1'b0, 1'b1);
        chk(32'(o_ipg_nibbles), 32'h0000_3FFF);
        // low word first so the high half is a matching snapshot
        apb(1'b0, 12'h100, '0);
        chk(q, 32'h0001_07CF);
        apb(1'b0, 12'h104, '0);
        chk(q, 32'h0000_0000);
        apb(1'b1, 12'h160, 32'hFFFF_FFFF);
        apb(1'b0, 12'h160, '0);
        chk(q, 32'(mc));
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        apb(1'b0, 12'h004, '0);
        chk(q, emcs_pkg::NCFG_WMASK);
        apb(1'b0, 12'h008, '0);
        chk(q, 32'h0000_0000);
        i_rst <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        apb(1'b0, 12'h160, '0);
        chk(q, 32'h0000_0000);
        end_sim();
    end
    // whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        errors++;
        end_sim();
    end
endmodule // testbench

// [verilog/emcs_pkg.sv]
// emcs_pkg: constants and carrier types for the mac config and stats block
package emcs_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_NETWORK_CONFIGURATION = 12'h004;
    localparam logic [11:0] OFS_TX_OCTETS_LOW         = 12'h100;
    localparam logic [11:0] OFS_TX_OCTETS_HIGH        = 12'h104;
    localparam logic [11:0] OFS_MULTICAST_RX_COUNT    = 12'h160;
    localparam logic [11:0] OFS_FCS_ERROR_COUNT       = 12'h190;

    // ------------------------------------------------------------------
    // network configuration fields and reset
    // ------------------------------------------------------------------
    localparam logic [31:0] NCFG_RESET     = 32'h0008_0000;
    localparam logic [31:0] NCFG_WMASK     = 32'hFEFF_FFFF;
    localparam int          BIT_IGN_RXERR  = 30;
    localparam int          BIT_BAD_PREAMB = 29;
    localparam int          BIT_GAP_STRCH  = 28;
    localparam int          BIT_IGN_FCS    = 26;
    localparam int          BIT_HD_RX_TX   = 25;
    localparam int          BIT_FULL_DUPLX = 1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          IPG_BIT_TIMES  = 96;
    localparam int          IPG_NIBBLES    = IPG_BIT_TIMES / 4;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;

    // one completed frame reported on the link side
    typedef struct packed {
        logic        ok;
        logic        fcs_bad;
        logic        multicast;
    } emcs_rx_frame_t;

    typedef struct packed {
        logic [15:0] len;
        logic        pause_auto;
        logic        ok;
    } emcs_tx_frame_t;

endpackage

// [verilog/emcs_top.sv]
// emcs_top: configuration register, frame acceptance and statistics
`timescale 1ns/1ps
module emcs_top #(
    parameter int STRETCH_DIV = 4
) (
    // system
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // phy receive, link clock domain
    input  wire logic        i_clk_link,
    input  wire logic        i_rx_valid_input,
    input  wire logic        i_rx_error_input,
    input  wire logic        i_rx_sfd_ok,
    input  wire logic        i_rx_preamble_bad,
    input  wire logic        i_rx_fcs_bad,
    input  wire logic        i_rx_multicast,
    input  wire logic        i_rx_pause,
    input  wire logic        i_rx_filter_pass,
    input  wire logic        i_rx_mem_copied,
    input  wire logic        i_rx_end,
    // transmit side, system domain
    input  wire logic        i_tx_busy,
    input  wire logic        i_tx_done,
    input  wire logic [15:0] i_tx_len,
    input  wire logic        i_tx_pause_auto,
    input  wire logic        i_tx_ok,
    // status
    output logic             o_rx_frame_keep,
    output logic             o_rx_fcs_status,
    output logic             o_rx_status_valid,
    output logic      [15:0] o_ipg_nibbles
);

    // ------------------------------------------------------------------
    // link domain state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        bad;
        emcs_pkg::emcs_rx_frame_t fr;
        logic        tgl;
        logic [1:0]  cfg_s1;
        logic [1:0]  cfg_s2;
        logic [1:0]  tx_s1;
        logic [1:0]  tx_s2;
    } emcs_lnk_t;

    emcs_lnk_t l_reg;
    emcs_lnk_t l_next;

    typedef struct packed {
        logic [31:0] ncfg;
        logic [47:0] tx_octet_count;
        logic [15:0] txo_hi_snap;
        logic [31:0] multicast_rx_frame_count;
        logic [31:0] fcs_cnt;
        logic [3:0]  tgl_s;
        emcs_pkg::emcs_rx_frame_t fr_s1;
        emcs_pkg::emcs_rx_frame_t fr_s2;
        logic [31:0] rdata;
        logic        keep;
        logic        fcs_st;
        logic        st_vld;
        logic [15:0] last_len;
        logic [15:0] ipg;
    } emcs_sys_t;

    emcs_sys_t s_reg;
    emcs_sys_t s_next;

    logic hd_ok;

    // ------------------------------------------------------------------
    // link domain receive qualification
    // ------------------------------------------------------------------
    always_comb begin
        l_next        = l_reg;
        l_next.cfg_s1 = {s_reg.ncfg[emcs_pkg::BIT_IGN_RXERR],
                         s_reg.ncfg[emcs_pkg::BIT_BAD_PREAMB]};
        l_next.cfg_s2 = l_reg.cfg_s1;
        l_next.tx_s1  = {i_tx_busy, s_reg.ncfg[emcs_pkg::BIT_HD_RX_TX]
                         | s_reg.ncfg[emcs_pkg::BIT_FULL_DUPLX]};
        l_next.tx_s2  = l_reg.tx_s1;
        hd_ok         = !l_reg.tx_s2[1] || l_reg.tx_s2[0];
        if (i_rx_error_input && (i_rx_valid_input || !l_reg.cfg_s2[1])) begin
            l_next.bad = 1'b1;
        end
        if (i_rx_valid_input && i_rx_preamble_bad && !l_reg.cfg_s2[0]) begin
            l_next.bad = 1'b1;
        end
        if (i_rx_valid_input && !hd_ok) begin
            l_next.bad = 1'b1;
        end
        if (i_rx_end) begin
            l_next.fr.ok        = !l_next.bad && i_rx_sfd_ok;
            l_next.fr.fcs_bad   = i_rx_fcs_bad;
            l_next.fr.multicast = i_rx_multicast && !i_rx_pause
                                  && i_rx_filter_pass && i_rx_mem_copied;
            l_next.tgl          = !l_reg.tgl;
            l_next.bad          = 1'b0;
        end
    end

    always_ff @(posedge i_clk_link) begin
        if (i_rst) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    // ------------------------------------------------------------------
    // system domain: registers, counters, gap
    // ------------------------------------------------------------------
    logic        wr;
    logic        rd;
    logic        ev;
    logic        keep;
    logic [15:0] stretch;

    always_comb begin
        s_next       = s_reg;
        wr           = i_psel && i_penable && i_pwrite;
        rd           = i_psel && !i_penable && !i_pwrite;
        s_next.tgl_s = {s_reg.tgl_s[2:0], l_reg.tgl};
        // fields held for many link cycles; the extra toggle stage lets
        // fr_s2 hold a copy taken after the toggle had already settled
        s_next.fr_s1 = l_reg.fr;
        s_next.fr_s2 = s_reg.fr_s1;
        ev           = s_reg.tgl_s[3] ^ s_reg.tgl_s[2];
        s_next.st_vld = ev;
        if (wr && i_paddr == emcs_pkg::OFS_NETWORK_CONFIGURATION) begin
            s_next.ncfg = i_pwdata & emcs_pkg::NCFG_WMASK;
        end
        keep = 1'b0;
        if (ev) begin
            keep = s_reg.fr_s2.ok && (!s_reg.fr_s2.fcs_bad
                   || s_reg.ncfg[emcs_pkg::BIT_IGN_FCS]);
            s_next.keep   = keep;
            s_next.fcs_st = s_reg.fr_s2.fcs_bad;
            if (s_reg.fr_s2.fcs_bad) begin
                s_next.fcs_cnt = s_reg.fcs_cnt + 32'h0000_0001;
            end
            if (keep && !s_reg.fr_s2.fcs_bad && s_reg.fr_s2.multicast) begin
                s_next.multicast_rx_frame_count = s_reg.multicast_rx_frame_count + 32'h0000_0001;
            end
        end
        if (i_tx_done) begin
            s_next.last_len = i_tx_len;
            if (i_tx_ok && !i_tx_pause_auto) begin
                s_next.tx_octet_count = s_reg.tx_octet_count + {32'h0000_0000, i_tx_len};
            end
        end
        stretch = 16'(s_reg.last_len / 16'(STRETCH_DIV));
        if (s_reg.ncfg[emcs_pkg::BIT_GAP_STRCH]
            && stretch > 16'(emcs_pkg::IPG_NIBBLES)) begin
            s_next.ipg = stretch;
        end else begin
            s_next.ipg = 16'(emcs_pkg::IPG_NIBBLES);
        end
        if (rd) begin
            case (i_paddr)
                emcs_pkg::OFS_NETWORK_CONFIGURATION: begin
                    s_next.rdata = s_reg.ncfg;
                end
                emcs_pkg::OFS_TX_OCTETS_LOW: begin
                    s_next.rdata       = s_reg.tx_octet_count[31:0];
                    s_next.txo_hi_snap = s_reg.tx_octet_count[47:32];
                end
                emcs_pkg::OFS_TX_OCTETS_HIGH: begin
                    s_next.rdata = {emcs_pkg::COUNT_ZERO, s_reg.txo_hi_snap};
                end
                emcs_pkg::OFS_MULTICAST_RX_COUNT: begin
                    s_next.rdata = s_reg.multicast_rx_frame_count;
                end
                emcs_pkg::OFS_FCS_ERROR_COUNT: begin
                    s_next.rdata = s_reg.fcs_cnt;
                end
                default: begin
                    s_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_reg      <= '0;
            s_reg.ncfg <= emcs_pkg::NCFG_RESET;
            s_reg.ipg  <= 16'(emcs_pkg::IPG_NIBBLES);
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_prdata          = s_reg.rdata;
    assign o_pready          = 1'b1;
    assign o_pslverr         = 1'b0;
    assign o_rx_frame_keep   = s_reg.keep;
    assign o_rx_fcs_status   = s_reg.fcs_st;
    assign o_rx_status_valid = s_reg.st_vld;
    assign o_ipg_nibbles     = s_reg.ipg;

endmodule // emcs_top
